// ---- pkg/twm_pkg.sv ----
// Purpose: constants and types of the two-wire master transmitter
// Assumes: APB register access, 32-bit data, one word per register
// Notes: status codes are byte values, the status register holds bits 7:3
// ----------------------------------------------------------------
// How it works
// - four modes exist; only master modes and unaddressed slave are built here
// - start request with flag write waits for a free bus, then drives START
// - after START the flag sets and status reads $08
// - direction bit of first address picks master transmit or master receive
// - after address and acknowledge the flag sets with $18, $20, $40 or $48, or $38 on lost arbitration
// - while the flag is set the bus transfer stays suspended
// - data write with flag low is dropped and sets write collision
// - stop request with flag write drives STOP on the bus while owning it
// - start request with flag write while owning the bus gives repeated START
// - after repeated START status reads $10 and bus ownership is kept
// - status code sits in bits 7:3, prescaler bits read apart
// - after each data byte and its acknowledge the flag sets with data status
// - write bit low, read bit high, acknowledge low, bytes of eight bits
// - after lost arbitration a clear without start releases the bus
// - stop request bit clears itself after STOP, pending start follows
// ----------------------------------------------------------------
package twm_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_RATE = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
	localparam logic [7:0] OFS_IRQ_EN = 8'h18;
	// control register bit positions
	localparam int B_FLAG = 7;
	localparam int B_ACK_EN = 6;
	localparam int B_STA = 5;
	localparam int B_STO = 4;
	localparam int B_WC = 3;
	localparam int B_EN = 2;
	localparam int B_IE = 0;
	// interrupt status bit positions
	localparam int I_FLAG = 0;
	localparam int I_WC = 1;
	localparam int I_LOST = 2;
	// status codes
	localparam logic [7:0] ST_START = 8'h08;
	localparam logic [7:0] ST_RSTART = 8'h10;
	localparam logic [7:0] ST_AW_ACK = 8'h18;
	localparam logic [7:0] ST_AW_NACK = 8'h20;
	localparam logic [7:0] ST_DW_ACK = 8'h28;
	localparam logic [7:0] ST_DW_NACK = 8'h30;
	localparam logic [7:0] ST_LOST = 8'h38;
	localparam logic [7:0] ST_AR_ACK = 8'h40;
	localparam logic [7:0] ST_AR_NACK = 8'h48;
	localparam logic [7:0] ST_DR_ACK = 8'h50;
	localparam logic [7:0] ST_DR_NACK = 8'h58;
	localparam logic [7:0] ST_NONE = 8'hf8;
	localparam logic [7:0] CODE_MASK = 8'hf8;
	// reset values and last bit index
	localparam logic [7:0] RST_DATA = 8'hff;
	localparam logic [7:0] RST_RATE = 8'h0f;
	localparam logic [2:0] BIT_LAST = 3'h7;
	typedef enum logic [2:0] {S_IDLE, S_WAIT, S_START, S_BIT, S_ACK, S_STOP, S_HOLD} twm_state_t;
endpackage

// ---- hw/twm_master.sv ----
// Purpose: two-wire bus master with APB registers and byte level handshake
// Assumes: scl and sda inputs are synchronous to pclk, open-drain pads outside
// Notes: slave modes are limited to the unaddressed state
//
// The APB slave port and the register addresses were chosen for this implementation.
module twm_master
	import twm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		twm_state_t st;
		logic [1:0] ph;
		logic [2:0] bitcnt;
		logic [7:0] sh;
		logic [14:0] cnt;
		logic master;
		logic rx;
		logic aphase;
		logic rs;
		logic ackb;
		logic busy;
		logic scl_p;
		logic sda_p;
		logic scl_oe;
		logic sda_oe;
		logic scl_o;
		logic sda_o;
		logic flag;
		logic ack_en;
		logic sta;
		logic sto;
		logic wc;
		logic en;
		logic ie;
		logic [4:0] code;
		logic [1:0] ps;
		logic [7:0] data;
		logic [7:0] rate;
		logic [2:0] ist;
		logic [2:0] ien;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} twm_regs_t;

	twm_regs_t state_reg;
	twm_regs_t state_next;
	logic tick;
	logic wr;
	logic wr_ctrl;
	logic launch;
	logic kill;
	logic rxdata;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_DATA) || (a == OFS_RATE) ||
			(a == OFS_IRQ_STAT) || (a == OFS_IRQ_CLR) || (a == OFS_IRQ_EN);
	endfunction

	function automatic logic [7:0] rd(input logic [7:0] a, input twm_regs_t r);
		rd = 8'h00;
		unique case (a)
			OFS_CTRL: rd = {r.flag, r.ack_en, r.sta, r.sto, r.wc, r.en, 1'b0, r.ie};
			OFS_STATUS: rd = {r.code, 1'b0, r.ps};
			OFS_DATA: rd = r.data;
			OFS_RATE: rd = r.rate;
			OFS_IRQ_STAT: rd = {5'h00, r.ist};
			OFS_IRQ_EN: rd = {5'h00, r.ien};
			default: rd = 8'h00;
		endcase
	endfunction

	// quarter bit period: (rate + 1) * 4^ps cycles
	function automatic logic [14:0] qlim(input logic [7:0] rate, input logic [1:0] ps);
		qlim = (({7'h00, rate} + 15'h0001) << {ps, 1'b0}) - 15'h0001;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		tick = (state_reg.cnt == qlim(state_reg.rate, state_reg.ps));
		wr = psel && penable && state_reg.pready && pwrite && mapped(paddr);
		wr_ctrl = wr && (paddr == OFS_CTRL);
		kill = wr_ctrl && !pwdata[B_EN];
		launch = wr_ctrl && pwdata[B_FLAG] && (state_reg.st inside {S_IDLE, S_HOLD, S_WAIT});
		rxdata = state_reg.rx && !state_reg.aphase;
		state_next.pready = 1'b0;
		state_next.pslverr = 1'b0;
		state_next.scl_p = scl_i;
		state_next.sda_p = sda_i;
		state_next.scl_o = 1'b0;
		state_next.sda_o = 1'b0;
		// bus busy between a seen START and a seen STOP
		if (scl_i && state_reg.scl_p && state_reg.sda_p && !sda_i) begin
			state_next.busy = 1'b1;
		end else if (scl_i && state_reg.scl_p && !state_reg.sda_p && sda_i) begin
			state_next.busy = 1'b0;
		end
		if (state_reg.st inside {S_IDLE, S_HOLD} || tick) begin
			state_next.cnt = 15'h0000;
		end else begin
			state_next.cnt = state_reg.cnt + 15'h0001;
		end
		// first access cycle answers, second one commits
		if (psel && penable && !state_reg.pready) begin
			state_next.pready = 1'b1;
			state_next.pslverr = !mapped(paddr);
			state_next.prdata = {24'h000000, rd(paddr, state_reg)};
		end

		// ------------------------------------------------------------
		// software side
		// ------------------------------------------------------------
		if (wr_ctrl) begin
			state_next.ack_en = pwdata[B_ACK_EN];
			state_next.sta = pwdata[B_STA];
			state_next.sto = pwdata[B_STO];
			state_next.en = pwdata[B_EN];
			state_next.ie = pwdata[B_IE];
			if (pwdata[B_FLAG]) begin
				state_next.flag = 1'b0;
			end
		end
		if (kill) begin
			state_next.st = S_IDLE;
			state_next.master = 1'b0;
			state_next.scl_oe = 1'b0;
			state_next.sda_oe = 1'b0;
		end else if (launch) begin
			state_next.cnt = 15'h0000;
			state_next.ph = 2'd0;
			if (pwdata[B_STO]) begin
				if (state_reg.master) begin
					state_next.st = S_STOP;
				end else begin
					state_next.sto = 1'b0;
					state_next.st = pwdata[B_STA] ? S_WAIT : S_IDLE;
				end
			end else if (pwdata[B_STA]) begin
				state_next.rs = state_reg.master;
				state_next.st = state_reg.master ? S_START : S_WAIT;
			end else if (state_reg.master && state_reg.st == S_HOLD) begin
				state_next.st = S_BIT;
				state_next.bitcnt = 3'h0;
				state_next.sh = state_reg.data;
				if (state_reg.aphase) begin
					state_next.rx = state_reg.data[0];
				end
			end else begin
				// released bus: back to unaddressed slave
				state_next.st = S_IDLE;
				state_next.scl_oe = 1'b0;
				state_next.sda_oe = 1'b0;
			end
		end
		if (wr && paddr == OFS_DATA) begin
			if (state_reg.flag) begin
				state_next.data = pwdata[7:0];
				state_next.wc = 1'b0;
			end else begin
				state_next.wc = 1'b1;
				state_next.ist[I_WC] = 1'b1;
			end
		end
		if (wr && paddr == OFS_STATUS) begin
			state_next.ps = pwdata[1:0];
		end
		if (wr && paddr == OFS_RATE) begin
			state_next.rate = pwdata[7:0];
		end
		if (wr && paddr == OFS_IRQ_EN) begin
			state_next.ien = pwdata[2:0];
		end
		if (wr && paddr == OFS_IRQ_CLR) begin
			state_next.ist = state_next.ist & ~pwdata[2:0];
		end

		// ------------------------------------------------------------
		// bus engine; hardware sets come last so a set wins a clear
		// ------------------------------------------------------------
		if (!kill) begin
			unique case (state_reg.st)
				S_IDLE, S_HOLD: begin
				end
				S_WAIT: begin
					if (!launch && !state_reg.busy && scl_i && sda_i) begin
						state_next.st = S_START;
						state_next.ph = 2'd0;
						state_next.rs = 1'b0;
					end
				end
				S_START: begin
					if (tick) begin
						unique case (state_reg.ph)
							2'd0: begin
								state_next.sda_oe = 1'b0;
								state_next.ph = 2'd1;
							end
							2'd1: begin
								state_next.scl_oe = 1'b0;
								state_next.ph = 2'd2;
							end
							2'd2: begin
								// wait out clock stretching before the falling sda
								if (scl_i) begin
									state_next.sda_oe = 1'b1;
									state_next.ph = 2'd3;
								end
							end
							2'd3: begin
								state_next.scl_oe = 1'b1;
								state_next.flag = 1'b1;
								state_next.ist[I_FLAG] = 1'b1;
								state_next.code = state_reg.rs ? ST_RSTART[7:3] : ST_START[7:3];
								state_next.master = 1'b1;
								state_next.aphase = 1'b1;
								state_next.st = S_HOLD;
							end
						endcase
					end
				end
				S_BIT: begin
					if (tick) begin
						unique case (state_reg.ph)
							2'd0: begin
								state_next.sda_oe = rxdata ? 1'b0 : !state_reg.sh[7];
								state_next.ph = 2'd1;
							end
							2'd1: begin
								state_next.scl_oe = 1'b0;
								state_next.ph = 2'd2;
							end
							2'd2: begin
								if (scl_i) begin
									if (!rxdata && !state_reg.sda_oe && !sda_i) begin
										// another master pulled a one low
										state_next.st = S_HOLD;
										state_next.scl_oe = 1'b0;
										state_next.sda_oe = 1'b0;
										state_next.master = 1'b0;
										state_next.flag = 1'b1;
										state_next.ist[I_FLAG] = 1'b1;
										state_next.ist[I_LOST] = 1'b1;
										state_next.code = ST_LOST[7:3];
									end else begin
										state_next.sh = {state_reg.sh[6:0], sda_i};
										state_next.ph = 2'd3;
									end
								end
							end
							2'd3: begin
								state_next.scl_oe = 1'b1;
								state_next.bitcnt = state_reg.bitcnt + 3'h1;
								state_next.ph = 2'd0;
								if (state_reg.bitcnt == BIT_LAST) begin
									state_next.st = S_ACK;
									if (rxdata) begin
										state_next.data = state_reg.sh;
									end
								end
							end
						endcase
					end
				end
				S_ACK: begin
					if (tick) begin
						unique case (state_reg.ph)
							2'd0: begin
								state_next.sda_oe = rxdata && state_reg.ack_en;
								state_next.ph = 2'd1;
							end
							2'd1: begin
								state_next.scl_oe = 1'b0;
								state_next.ph = 2'd2;
							end
							2'd2: begin
								if (scl_i) begin
									state_next.ackb = rxdata ? !state_reg.ack_en : sda_i;
									state_next.ph = 2'd3;
								end
							end
							2'd3: begin
								state_next.scl_oe = 1'b1;
								state_next.sda_oe = 1'b0;
								state_next.flag = 1'b1;
								state_next.ist[I_FLAG] = 1'b1;
								state_next.aphase = 1'b0;
								state_next.st = S_HOLD;
								unique case ({state_reg.aphase, state_reg.rx})
									2'b10: state_next.code = state_reg.ackb ? ST_AW_NACK[7:3] : ST_AW_ACK[7:3];
									2'b11: state_next.code = state_reg.ackb ? ST_AR_NACK[7:3] : ST_AR_ACK[7:3];
									2'b00: state_next.code = state_reg.ackb ? ST_DW_NACK[7:3] : ST_DW_ACK[7:3];
									2'b01: state_next.code = state_reg.ackb ? ST_DR_NACK[7:3] : ST_DR_ACK[7:3];
								endcase
							end
						endcase
					end
				end
				S_STOP: begin
					if (tick) begin
						unique case (state_reg.ph)
							2'd0: begin
								state_next.sda_oe = 1'b1;
								state_next.ph = 2'd1;
							end
							2'd1: begin
								state_next.scl_oe = 1'b0;
								state_next.ph = 2'd2;
							end
							2'd2: begin
								if (scl_i) begin
									state_next.sda_oe = 1'b0;
									state_next.ph = 2'd3;
								end
							end
							2'd3: begin
								// no flag here: software sees the stop as sto low and status $F8
								state_next.sto = 1'b0;
								state_next.master = 1'b0;
								state_next.code = ST_NONE[7:3];
								state_next.st = state_reg.sta ? S_WAIT : S_IDLE;
								state_next.ph = 2'd0;
							end
						endcase
					end
				end
			endcase
		end
		state_next.irq = |(state_next.ist & state_next.ien) || (state_next.flag && state_next.ie);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
			state_reg.st <= S_IDLE;
			state_reg.code <= ST_NONE[7:3];
			state_reg.data <= RST_DATA;
			state_reg.rate <= RST_RATE;
			state_reg.scl_p <= 1'b1;
			state_reg.sda_p <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign scl_o = state_reg.scl_o;
	assign scl_oe = state_reg.scl_oe;
	assign sda_o = state_reg.sda_o;
	assign sda_oe = state_reg.sda_oe;
	assign irq = state_reg.irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence start_done;
		state_reg.st == S_START && state_reg.ph == 2'd3 && tick;
	endsequence
	sequence addr_ack_done;
		state_reg.st == S_ACK && state_reg.ph == 2'd3 && tick && state_reg.aphase;
	endsequence

	a_start_code: assert property (start_done and !state_reg.rs |=>
		state_reg.flag && {state_reg.code, 3'h0} == ST_START && state_reg.st == S_HOLD)
		else $error("start did not report its code");
	a_rstart_code: assert property (start_done and state_reg.rs |=>
		{state_reg.code, 3'h0} == ST_RSTART && state_reg.master)
		else $error("repeated start code wrong");
	a_addr_status: assert property (addr_ack_done and !state_reg.rx |=>
		state_reg.flag && ({state_reg.code, 3'h0} == ($past(state_reg.ackb) ? ST_AW_NACK : ST_AW_ACK)))
		else $error("address status wrong");
	a_data_status: assert property (state_reg.st == S_ACK && state_reg.ph == 2'd3 && tick &&
		!state_reg.aphase && !state_reg.rx |=> state_reg.flag && !state_reg.aphase &&
		({state_reg.code, 3'h0} == ST_DW_ACK || {state_reg.code, 3'h0} == ST_DW_NACK))
		else $error("data status wrong");
	a_hold_stalls: assert property (state_reg.st == S_HOLD && state_reg.flag && !wr_ctrl |=>
		state_reg.st == S_HOLD && $stable(state_reg.scl_oe))
		else $error("transfer moved while flag set");
	a_collision_bit: assert property (wr && paddr == OFS_DATA && !state_reg.flag |=>
		state_reg.wc && $stable(state_reg.data))
		else $error("collision not flagged");
	a_bus_free_wait: assert property (state_reg.st == S_WAIT && state_reg.busy && !launch && !kill |=>
		state_reg.st == S_WAIT)
		else $error("start while bus busy");
	a_stop_clears: assert property (state_reg.st == S_STOP && state_reg.ph == 2'd3 && tick && !kill |=>
		!state_reg.sto && !state_reg.sda_oe && !state_reg.master)
		else $error("stop request not cleared");
	a_dir_bit_line: assert property (state_reg.st == S_BIT && state_reg.ph inside {2'd1, 2'd2} &&
		!rxdata |-> state_reg.sda_oe == !state_reg.sh[7])
		else $error("sda does not follow the bit");
	a_mode_select: assert property (launch && !kill && state_reg.aphase && state_reg.master &&
		state_reg.st == S_HOLD && !pwdata[B_STA] && !pwdata[B_STO] |=> state_reg.rx == $past(state_reg.data[0]))
		else $error("mode not taken from direction bit");
	a_flag_write_one: assert property (wr_ctrl && pwdata[B_FLAG] |=> !state_reg.flag)
		else $error("flag not cleared by one");
	a_flag_write_zero: assert property (wr_ctrl && !pwdata[B_FLAG] && state_reg.flag |=> state_reg.flag)
		else $error("flag cleared by zero");
	a_lost_release: assert property (launch && !kill && !state_reg.master && !pwdata[B_STA] &&
		!pwdata[B_STO] |=> state_reg.st == S_IDLE && !state_reg.scl_oe && !state_reg.sda_oe)
		else $error("bus not released after lost arbitration");
	a_status_mask: assert property (state_reg.pready && $past(paddr) == OFS_STATUS |->
		state_reg.prdata[2] == 1'b0 && state_reg.prdata[31:8] == 24'h000000)
		else $error("status low bits wrong");

endmodule

// ---- tb/twm_slave_model.sv ----
// Purpose: behavioural two-wire slave receiver that stands on the far side of the master
// Assumes: open-drain lines resolved by the bench, sampled on pclk
// Notes: acks or refuses per the nack input, stretches scl low for stretch cycles per bit
module twm_slave_model (
	input wire logic pclk,
	input wire logic scl,
	input wire logic sda,
	input wire logic nack,
	input wire logic [3:0] stretch,
	output logic scl_oe,
	output logic sda_oe,
	output logic [7:0] rx_byte,
	output logic rx_valid
);
	timeunit 1ns;
	timeprecision 100ps;
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic ack_q = 1'b0;
	logic got_q = 1'b0;
	logic [3:0] bits = 4'h0;
	logic [3:0] hold = 4'h0;
	logic [7:0] shift = 8'h00;
	assign scl_oe = hold != 4'h0;
	assign sda_oe = ack_q;
	assign rx_byte = shift;
	assign rx_valid = got_q;
	always @(posedge pclk) begin
		scl_q <= scl;
		sda_q <= sda;
		got_q <= 1'b0;
		if (hold != 4'h0) begin
			hold <= hold - 4'h1;
		end
		if (scl && scl_q && sda !== sda_q) begin
			// start or stop seen: frame restarts
			bits <= 4'h0;
			ack_q <= 1'b0;
		end else if (scl && !scl_q) begin
			if (bits < 4'h8) begin
				shift <= {shift[6:0], sda}; // msb first, eight bits
			end
			got_q <= bits == 4'h7;
			bits <= bits + 4'h1;
		end else if (!scl && scl_q) begin
			ack_q <= bits == 4'h8 && !nack; // ack pulls low, refusal leaves high
			// slow answer: clock held low, master must wait
			hold <= stretch;
			if (bits == 4'h9) begin
				bits <= 4'h0;
			end
		end
	end
endmodule

// ---- tb/two_wire_master_transmit_test.sv ----
// Purpose: self-checking bench for the two-wire master over APB
// Assumes: pull-ups on both lines, one slave model, one rogue pull-down
// Notes: a short quarter keeps the run small; expected bytes are queued by send and compared with the slave model
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module two_wire_master_transmit_test
	import twm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic scl_oe, sda_oe, s_scl_oe, s_sda_oe, other_low, slave_nack, rx_valid;
	logic [3:0] slave_stretch;
	logic [7:0] rx_byte;
	logic [7:0] exp_q[$];
	logic [7:0] got_q[$];
	int mismatches = 0;
	int check_count = 0;
	wire scl = !(scl_oe || s_scl_oe);
	wire sda = !(sda_oe || s_sda_oe || other_low);
	twm_master dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
		.sda_oe(sda_oe), .irq(irq));
	twm_slave_model slave (.pclk(pclk), .scl(scl), .sda(sda), .nack(slave_nack),
		.stretch(slave_stretch), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .rx_byte(rx_byte),
		.rx_valid(rx_valid));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		`CHK("apb answer", 1'b1, pready);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask
	task automatic wait_flag(input logic [7:0] code);
		logic [31:0] q;
		int n;
		n = 0;
		q = 32'h0;
		while (q[B_FLAG] !== 1'b1 && n < 400) begin
			rd(OFS_CTRL, q);
			n++;
		end
		`CHK("flag raised", 1'b1, q[B_FLAG]);
		rd(OFS_STATUS, q);
		`CHK("status code", code, q & 32'(CODE_MASK));
	endtask
	task automatic send(input logic [7:0] b, input logic nk, input logic [7:0] code);
		wr(OFS_DATA, {24'h0, b});
		slave_nack <= nk;
		wr(OFS_CTRL, 32'h84);
		exp_q.push_back(b);
		wait_flag(code);
	endtask
	always @(posedge pclk) begin
		if (rx_valid === 1'b1) begin
			got_q.push_back(rx_byte);
		end
	end
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		#(40 * 40000);
		mismatches++;
		$display("[FAIL] watchdog expected finish seen hang");
		test_done();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] q;
		logic e;
		logic [6:0] sa;
		logic [7:0] ofs[6];
		logic [7:0] rv[6];
		int n;
		ofs = '{OFS_CTRL, OFS_STATUS, OFS_DATA, OFS_RATE, OFS_IRQ_STAT, OFS_IRQ_EN};
		rv = '{8'h00, 8'hf8, 8'hff, 8'h0f, 8'h00, 8'h00};
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{other_low, slave_nack, slave_stretch} = '0;
		void'($urandom(32'h1a62163e));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ofs[k]) begin
			rd(ofs[k], q);
			`CHK($sformatf("reset of %h", ofs[k]), rv[k], q);
		end
		apb(1'b0, 8'h1c, 32'h0, q, e);
		`CHK("unmapped error", 1'b1, e);
		wr(OFS_CTRL, 32'h04);
		wr(OFS_DATA, 32'h5a);
		rd(OFS_CTRL, q);
		`CHK("collision bit", 1'b1, q[B_WC]);
		rd(OFS_DATA, q);
		`CHK("data kept", 8'hff, q);
		`CHK("irq masked", 1'b0, irq);
		wr(OFS_IRQ_EN, 32'h1 << I_WC);
		repeat (2) @(posedge pclk);
		`CHK("irq raised", 1'b1, irq);
		wr(OFS_IRQ_CLR, 32'h1 << I_WC);
		repeat (2) @(posedge pclk);
		`CHK("irq cleared", 1'b0, irq);
		wr(OFS_IRQ_EN, 32'h0);
		$display("test registers done");
		// rate zero with prescaler 1 gives a four-cycle quarter, plus a long stretch: every bit after the first of a byte must wait on the slave
		wr(OFS_RATE, 32'h0);
		wr(OFS_STATUS, 32'h1);
		rd(OFS_STATUS, q);
		`CHK("prescaler bits", 2'h1, q[1:0]);
		slave_stretch <= 4'($urandom_range(12, 15));
		wr(OFS_CTRL, 32'ha4);
		wait_flag(ST_START);
		wr(OFS_CTRL, 32'h04);
		rd(OFS_CTRL, q);
		`CHK("flag kept", 1'b1, q[B_FLAG]);
		repeat (40) @(posedge pclk);
		`CHK("bus suspended", 1'b0, scl);
		sa = 7'($urandom_range(8, 119));
		send({sa, 1'b0}, 1'b0, ST_AW_ACK);
		for (int i = 0; i < 3; i++) begin
			send(8'($urandom), i == 2, (i == 2) ? ST_DW_NACK : ST_DW_ACK);
		end
		wr(OFS_CTRL, 32'ha4);
		wait_flag(ST_RSTART);
		send({sa + 7'h1, 1'b0}, 1'b1, ST_AW_NACK);
		wr(OFS_CTRL, 32'ha4);
		wait_flag(ST_RSTART);
		send({sa, 1'b1}, 1'b0, ST_AR_ACK);
		// stop with start pending: the stop goes out, then a fresh start follows
		wr(OFS_CTRL, 32'hb4);
		wait_flag(ST_START);
		wr(OFS_CTRL, 32'h94);
		n = 0;
		q = 32'h10;
		while (q[B_STO] !== 1'b0 && n < 300) begin
			rd(OFS_CTRL, q);
			n++;
		end
		`CHK("stop bit cleared", 1'b0, q[B_STO]);
		`CHK("bus idle", 2'h3, {scl, sda});
		`CHK("byte count", exp_q.size(), got_q.size());
		foreach (exp_q[k]) begin
			`CHK("wire byte", exp_q[k], got_q[k]);
		end
		$display("test transfer done");
		// rogue master holds the bus, then wins the first address bit
		other_low <= 1'b1;
		wr(OFS_CTRL, 32'ha4);
		repeat (100) @(posedge pclk);
		rd(OFS_CTRL, q);
		`CHK("waits for free bus", 1'b0, q[B_FLAG]);
		other_low <= 1'b0;
		wait_flag(ST_START);
		wr(OFS_DATA, 32'hfe);
		other_low <= 1'b1;
		wr(OFS_CTRL, 32'h84);
		wait_flag(ST_LOST);
		rd(OFS_IRQ_STAT, q);
		`CHK("lost event", 1'b1, q[I_LOST]);
		wr(OFS_CTRL, 32'h84);
		repeat (2) @(posedge pclk);
		`CHK("bus released", 2'h0, {scl_oe, sda_oe});
		other_low <= 1'b0;
		$display("test arbitration done");
		test_done();
	end
endmodule
